// ===== emp_pkg.sv
// emp_pkg: constants and types shared by the expansion memory port.
// assumes a 100 MHz device clock and synchronous active-high reset.
package emp_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STROBE_TIME_NS   = 20;
  localparam int STROBE_CYCLES    =
    (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_TIME_NS   = 30;
  localparam int ACCESS_CYCLES    =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_EXTRA_CYCLES = 2;

  // ==========================================================
  // widths and straps
  localparam int ADDR_W       = 20;
  localparam int WIDE_ADDR_W  = 16;
  localparam int SIZE_W       = 3;
  localparam logic [2:0] SIZE_16K  = 3'h0;
  localparam logic [2:0] SIZE_64K  = 3'h2;
  localparam logic [2:0] SIZE_NONE = 3'h7;
  localparam int ROM_EN_BIT   = 0;
  localparam int IRQ_TOTEM_BIT = 3;

  // ==========================================================
  // types
  typedef enum logic [1:0] {EMP_BYTE_HI, EMP_BYTE_MID, EMP_BYTE_LO}
    emp_byte_t;

endpackage

// ===== emp_lane_if.sv
// emp_lane_if: byte lane routing signals between core and lane mux.
// assumes one clock domain; pure combinational carriage.
`timescale 1ns/1ps
interface emp_lane_if;
  logic       big_endian;
  logic [1:0] byte_index;
  logic [1:0] lane;

  modport core (output big_endian, output byte_index, input lane);
  modport mux  (input big_endian, input byte_index, output lane);
endinterface

// ===== emp_lane_map.sv
// emp_lane_map: maps byte order within a word to a pci byte lane.
// assumes byte_index counts transfer order, 0 first.
`timescale 1ns/1ps
module emp_lane_map
  import emp_pkg::*;
(
  emp_lane_if.mux lif
);

  // ==========================================================
  // lane selection
  always_comb
  begin
    if (lif.big_endian)
      lif.lane = 2'h3 - lif.byte_index; // RULE_12
    else
      lif.lane = lif.byte_index;        // RULE_10
  end

endmodule // emp_lane_map

// ===== emp_port.sv
// emp_port: external eprom/flash port with multiplexed address bus.
// assumes straps are stable while strap_load is high after reset.
// Operation
// RULE_01: build up to 20-bit address sent bytewise into external latches
// RULE_02: drive most significant address byte first, least significant last
// RULE_03: low strobe latches least significant address byte
// RULE_04: middle strobe latches address bits 15-8
// RULE_05: high strobe used only for wide memory strap and rom enable
// RULE_06: assert write enable low when writing flash
// RULE_07: assert output enable low during reads
// RULE_08: assert chip enable low during accesses
// RULE_09: after address, bus carries write data or samples read data
// RULE_10: little order, scsi-to-pci first byte to lane zero ascending
// RULE_11: little order, pci-to-scsi sends lane zero first ascending
// RULE_12: big order, scsi-to-pci first byte to lane three descending
// RULE_13: big order, pci-to-scsi sends lane three first descending
// RULE_14: little order flash write, lane zero to location zero ascending
// RULE_15: big order flash write, lane three to location zero descending
// RULE_16: interrupt low while service needed; open drain or totem pole
// RULE_17: test result on access pin only while test input low
// RULE_18: slow strap adds two cycles of data access time
// RULE_19: 3-bit size strap, 16 KB doubling, 111 means none
// RULE_20: hold address around strobes; strobes finish before enables
`timescale 1ns/1ps
module emp_port
  import emp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // straps, sampled from the bus while strap_load is high
  input  wire logic              strap_load,
  // access request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [31:0]       req_wdata,
  input  wire logic [1:0]        req_byte,
  output logic                   rsp_valid,
  output logic [31:0]            rsp_rdata,
  output logic                   rsp_error,
  // scsi stream lane routing
  input  wire logic              byte_order_select,
  input  wire logic [1:0]        stream_index,
  output logic [1:0]             stream_lane,
  // configuration bits
  input  wire logic              rom_base_enable,
  input  wire logic [7:0]        dma_control_reg,
  // external memory pins
  input  wire logic [7:0]        mem_addr_data_bus_in,
  output logic [7:0]             mem_addr_data_bus_out,
  output logic                   mem_addr_data_bus_oe,
  output logic                   addr_strobe_low,
  output logic                   addr_strobe_mid,
  output logic                   addr_strobe_high_out,
  output logic                   addr_strobe_high_oe,
  output logic                   mem_write_en_n,
  output logic                   mem_output_en_n,
  output logic                   mem_chip_en_n,
  output logic [10:0]            mem_size_kb,
  output logic                   mem_present,
  // interrupt pin
  input  wire logic              irq_pending,
  output logic                   irq_n_out,
  output logic                   irq_n_oe,
  // access indicator / test out
  input  wire logic              test_input_n,
  input  wire logic              and_tree_result,
  input  wire logic              local_access,
  output logic                   mem_access_test_out
);

  typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_HOLD, ST_DATA, ST_DONE}
    emp_state_t;

  emp_state_t          state_reg;
  emp_byte_t           byte_reg;
  logic [3:0]          cnt_reg;
  logic [SIZE_W-1:0]   size_reg;
  logic                slow_reg;
  logic                write_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [7:0]          data_reg;
  logic [1:0]          lane_reg;
  logic [31:0]         rdata_reg;
  logic                valid_reg;
  logic                err_reg;
  logic [3:0]          data_cycles;
  logic                wide;
  logic [ADDR_W-1:0]   limit;

  emp_lane_if stream_if ();
  emp_lane_if mem_if ();

  emp_lane_map u_stream_map (.lif(stream_if));
  emp_lane_map u_mem_map    (.lif(mem_if));

  // ==========================================================
  // lane routing
  assign stream_if.big_endian = byte_order_select;      // RULE_11
  assign stream_if.byte_index = stream_index;           // RULE_13
  assign stream_lane          = stream_if.lane;
  assign mem_if.big_endian    = byte_order_select;      // RULE_15
  assign mem_if.byte_index    = req_byte;               // RULE_14

  // ==========================================================
  // straps
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      size_reg <= SIZE_NONE;
      slow_reg <= 1'b0;
    end
    else if (strap_load)
    begin
      size_reg <= mem_addr_data_bus_in[3:1];            // RULE_19
      slow_reg <= ~mem_addr_data_bus_in[0];             // RULE_18
    end
  end

  assign mem_present = (size_reg != SIZE_NONE);         // RULE_19
  assign mem_size_kb = mem_present ?
                       (11'h010 << size_reg) : 11'h000;
  // more than 16 address bits needs 128 KB or larger
  assign wide  = mem_present && (size_reg > SIZE_64K)
                 && rom_base_enable;                    // RULE_05
  assign limit = mem_present ?
                 ADDR_W'((32'h4000 << size_reg) - 1) : '0;
  assign data_cycles = 4'(ACCESS_CYCLES)
                       + (slow_reg ? 4'(SLOW_EXTRA_CYCLES) : 4'h0);

  // ==========================================================
  // access sequencer
  assign req_ready = (state_reg == ST_IDLE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      byte_reg  <= EMP_BYTE_HI;
      cnt_reg   <= 4'h0;
      write_reg <= 1'b0;
      addr_reg  <= '0;
      data_reg  <= 8'h00;
      lane_reg  <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (req_valid && mem_present && (req_addr <= limit))
          begin
            write_reg <= req_write;
            addr_reg  <= req_addr;                      // RULE_01
            lane_reg  <= mem_if.lane;
            data_reg  <= req_wdata[mem_if.lane*8 +: 8];
            byte_reg  <= wide ? EMP_BYTE_HI : EMP_BYTE_MID; // RULE_02
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          // setup cycle: byte already on the bus before strobe
          cnt_reg   <= 4'(STROBE_CYCLES);
          state_reg <= ST_STROBE;                       // RULE_20
        end
        ST_STROBE:
        begin
          if (cnt_reg > 4'h1)
            cnt_reg <= cnt_reg - 4'h1;
          else
            state_reg <= ST_HOLD;
        end
        ST_HOLD:
        begin
          // hold cycle keeps the byte after the strobe rises
          if (byte_reg == EMP_BYTE_LO)
          begin
            cnt_reg   <= data_cycles;
            state_reg <= ST_DATA;                       // RULE_20
          end
          else
          begin
            byte_reg  <= (byte_reg == EMP_BYTE_HI) ?
                         EMP_BYTE_MID : EMP_BYTE_LO;    // RULE_02
            state_reg <= ST_ADDR;
          end
        end
        ST_DATA:
        begin
          if (cnt_reg > 4'h1)
            cnt_reg <= cnt_reg - 4'h1;                  // RULE_18
          else
            state_reg <= ST_DONE;
        end
        ST_DONE:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data capture and response
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
      if (state_reg == ST_DATA && cnt_reg == 4'h1)
      begin
        valid_reg <= 1'b1;
        if (!write_reg)
          rdata_reg[lane_reg*8 +: 8] <= mem_addr_data_bus_in; // RULE_09
      end
      else if (state_reg == ST_IDLE && req_valid &&
               !(mem_present && (req_addr <= limit)))
      begin
        valid_reg <= 1'b1;
        err_reg   <= 1'b1;
      end
    end
  end

  assign rsp_valid = valid_reg;
  assign rsp_rdata = rdata_reg;
  assign rsp_error = err_reg;

  // ==========================================================
  // pin drive
  logic addr_phase;
  logic [7:0] addr_byte;

  assign addr_phase = (state_reg == ST_ADDR) || (state_reg == ST_STROBE)
                      || (state_reg == ST_HOLD);

  always_comb
  begin
    unique case (byte_reg)
      EMP_BYTE_HI:  addr_byte = {4'h0, addr_reg[19:16]};
      EMP_BYTE_MID: addr_byte = addr_reg[15:8];
      EMP_BYTE_LO:  addr_byte = addr_reg[7:0];
      default:      addr_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_addr_data_bus_out <= 8'h00;
      mem_addr_data_bus_oe  <= 1'b0;
      addr_strobe_low       <= 1'b1;
      addr_strobe_mid       <= 1'b1;
      addr_strobe_high_out  <= 1'b1;
      mem_write_en_n        <= 1'b1;
      mem_output_en_n       <= 1'b1;
      mem_chip_en_n         <= 1'b1;
    end
    else
    begin
      mem_addr_data_bus_out <= addr_phase ? addr_byte : data_reg; // RULE_09
      mem_addr_data_bus_oe  <= addr_phase ||
                               (state_reg == ST_DATA && write_reg);
      addr_strobe_low  <= ~(state_reg == ST_STROBE &&
                            byte_reg == EMP_BYTE_LO);   // RULE_03
      addr_strobe_mid  <= ~(state_reg == ST_STROBE &&
                            byte_reg == EMP_BYTE_MID);  // RULE_04
      addr_strobe_high_out <= ~(state_reg == ST_STROBE &&
                                byte_reg == EMP_BYTE_HI); // RULE_05
      mem_chip_en_n    <= ~(state_reg == ST_DATA);      // RULE_08
      mem_output_en_n  <= ~(state_reg == ST_DATA && !write_reg); // RULE_07
      mem_write_en_n   <= ~(state_reg == ST_DATA && write_reg &&
                            cnt_reg != 4'h1);           // RULE_06
    end
  end

  // gpio pin stays an input unless wide memory is enabled
  assign addr_strobe_high_oe = wide;                    // RULE_05

  // ==========================================================
  // interrupt and test out
  // open drain drives only the low level; pull-up is external
  assign irq_n_out = ~irq_pending;                      // RULE_16
  assign irq_n_oe  = irq_pending ||
                     dma_control_reg[IRQ_TOTEM_BIT];    // RULE_16

  assign mem_access_test_out = test_input_n ? local_access
                                            : and_tree_result; // RULE_17

endmodule // emp_port

// ===== emp_port_chk.sv
// emp_port_chk: pin level checks bound onto emp_port.
// assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ps
module emp_port_chk
  import emp_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic        mem_present,
  input wire logic [10:0] mem_size_kb,
  input wire logic        rom_base_enable,
  input wire logic        byte_order_select,
  input wire logic [1:0]  stream_index,
  input wire logic [1:0]  stream_lane,
  input wire logic [7:0]  mem_addr_data_bus_out,
  input wire logic        mem_addr_data_bus_oe,
  input wire logic        addr_strobe_low,
  input wire logic        addr_strobe_mid,
  input wire logic        addr_strobe_high_out,
  input wire logic        addr_strobe_high_oe,
  input wire logic        mem_write_en_n,
  input wire logic        mem_output_en_n,
  input wire logic        mem_chip_en_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // address phase
  sequence mid_pulse_s;
    !addr_strobe_mid [*2] ##1 addr_strobe_mid;
  endsequence
  sequence low_next_s;
    addr_strobe_low [*2] ##1 !addr_strobe_low;
  endsequence
  sequence hi_pulse_s;
    !addr_strobe_high_out [*2] ##1 addr_strobe_high_out;
  endsequence
  sequence mid_next_s;
    addr_strobe_mid [*2] ##1 !addr_strobe_mid;
  endsequence
  mid_order_a: assert property ($fell(addr_strobe_mid) |->
    mid_pulse_s ##0 low_next_s) else $error("mid then low order");
  hi_order_a: assert property (addr_strobe_high_oe &&
    $fell(addr_strobe_high_out) |-> hi_pulse_s ##0 mid_next_s)
    else $error("high then mid order");
  addr_hold_a: assert property (!addr_strobe_low ||
    !addr_strobe_mid |-> mem_addr_data_bus_oe &&
    $stable(mem_addr_data_bus_out)) else $error("address moved");
  strobe_first_a: assert property (!addr_strobe_low ||
    !addr_strobe_mid |-> mem_output_en_n && mem_write_en_n)
    else $error("enable during strobe");
  wide_mode_a: assert property (addr_strobe_high_oe ==
    (rom_base_enable && mem_size_kb > 11'h040))
    else $error("high strobe mode wrong");
  // ==========================================================
  // data phase, idle pins, refusal and lane map
  read_en_a: assert property (!mem_output_en_n |->
    !mem_chip_en_n && !mem_addr_data_bus_oe) else $error("bad read");
  write_en_a: assert property (!mem_write_en_n |->
    !mem_chip_en_n && mem_addr_data_bus_oe) else $error("bad write");
  idle_pins_a: assert property (req_ready |-> mem_chip_en_n &&
    addr_strobe_low && addr_strobe_mid) else $error("idle pins busy");
  no_mem_a: assert property (req_valid && req_ready &&
    !mem_present |=> rsp_valid && rsp_error) else $error("no refusal");
  lane_map_a: assert property (stream_lane == (byte_order_select ?
    2'h3 - stream_index : stream_index)) else $error("lane wrong");
endmodule // emp_port_chk

bind emp_port emp_port_chk u_emp_port_chk (.clk, .sys_rst, .req_valid,
  .req_ready, .rsp_valid, .rsp_error, .mem_present, .mem_size_kb,
  .rom_base_enable, .byte_order_select, .stream_index, .stream_lane,
  .mem_addr_data_bus_out, .mem_addr_data_bus_oe, .addr_strobe_low,
  .addr_strobe_mid, .addr_strobe_high_out, .addr_strobe_high_oe,
  .mem_write_en_n, .mem_output_en_n, .mem_chip_en_n);

// ===== emp_mem_model.sv
// emp_mem_model: external latches plus an eprom/flash byte.
// assumes the bench resolves the shared bus with pull-ups.
`timescale 1ns/1ps
module emp_mem_model (
  input  wire logic [7:0] bus,
  input  wire logic       stb_low_n,
  input  wire logic       stb_mid_n,
  input  wire logic       stb_high_n,
  input  wire logic       ce_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  output logic            drv,
  output logic [7:0]      dat,
  output logic [19:0]     addr_reg,
  output logic [7:0]      wdata_reg
);
  // ==========================================================
  // latches clock on strobe release, so hold time matters
  always @(posedge stb_low_n) addr_reg[7:0] <= bus;
  always @(posedge stb_mid_n) addr_reg[15:8] <= bus;
  always @(posedge stb_high_n) addr_reg[19:16] <= bus[3:0];
  always @(posedge we_n) if (!ce_n) wdata_reg <= bus;
  assign drv = !ce_n && !oe_n;
  assign dat = addr_reg[7:0] ^ 8'hc3;
endmodule // emp_mem_model

// ===== tb_emp_port.sv
// tb_emp_port: self-checking bench for emp_port with memory model.
// assumes emp_port_chk is bound; straps come via the shared bus.
`timescale 1ns/1ps
module tb_emp_port;
  import emp_pkg::*;
  logic clk = 0, sys_rst = 1, strap_load = 0, req_valid = 0;
  logic req_write = 0, byte_order_select = 0, rom_base_enable = 0;
  logic irq_pending = 0, test_input_n = 1, and_tree_result = 0;
  logic local_access = 0, err, mdrv, hi_n;
  logic [ADDR_W-1:0] req_addr = '0, m_addr;
  logic [31:0] req_wdata = '0, rsp_rdata;
  logic [1:0] req_byte = '0, stream_index = '0, stream_lane;
  logic [7:0] dma_control_reg = '0, strap = 8'hff, mdat, m_wdata;
  logic [7:0] mem_addr_data_bus_out, mem_addr_data_bus_in;
  logic req_ready, rsp_valid, rsp_error, mem_addr_data_bus_oe;
  logic addr_strobe_low, addr_strobe_mid, addr_strobe_high_out;
  logic addr_strobe_high_oe, mem_write_en_n, mem_output_en_n;
  logic mem_chip_en_n, mem_present, irq_n_out, irq_n_oe;
  logic mem_access_test_out;
  logic [10:0] mem_size_kb;
  int fail_count = 0, n_checks = 0, cyc = 0, lat;
  // released bus floats high through the pin pull-ups
  assign mem_addr_data_bus_in = mem_addr_data_bus_oe ?
    mem_addr_data_bus_out : mdrv ? mdat : strap_load ? strap : 8'hff;
  assign hi_n = addr_strobe_high_oe ? addr_strobe_high_out : 1'b1;
  emp_port u_emp_port (.clk, .sys_rst, .strap_load, .req_valid,
    .req_ready, .req_write, .req_addr, .req_wdata, .req_byte, .rsp_valid,
    .rsp_rdata, .rsp_error, .byte_order_select, .stream_index,
    .stream_lane, .rom_base_enable, .dma_control_reg,
    .mem_addr_data_bus_in, .mem_addr_data_bus_out, .mem_addr_data_bus_oe,
    .addr_strobe_low, .addr_strobe_mid, .addr_strobe_high_out,
    .addr_strobe_high_oe, .mem_write_en_n, .mem_output_en_n,
    .mem_chip_en_n, .mem_size_kb, .mem_present, .irq_pending, .irq_n_out,
    .irq_n_oe, .test_input_n, .and_tree_result, .local_access,
    .mem_access_test_out);
  emp_mem_model u_emp_mem_model (.bus(mem_addr_data_bus_in),
    .stb_low_n(addr_strobe_low), .stb_mid_n(addr_strobe_mid),
    .stb_high_n(hi_n), .ce_n(mem_chip_en_n), .oe_n(mem_output_en_n),
    .we_n(mem_write_en_n), .drv(mdrv), .dat(mdat), .addr_reg(m_addr),
    .wdata_reg(m_wdata));
  always #5 clk = ~clk;
  // ==========================================================
  // helpers
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // called at a falling edge; returns at the edge showing rsp_valid
  task automatic acc(input logic w, input logic [19:0] a,
                     input logic [1:0] b);
    while (req_ready !== 1'b1)
      @(negedge clk);
    req_write = w;
    req_addr = a;
    req_byte = b;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 40)
    begin
      @(negedge clk);
      lat++;
    end
    err = rsp_error;
  endtask
  task automatic load(input logic [7:0] s);
    strap = s;
    strap_load = 1;
    @(negedge clk);
    strap_load = 0;
    @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_none();
    chk(mem_present, 0);
    acc(0, 20'h00010, 2'h0);
    chk(err, 1);
    chk(lat, 1);
  endtask
  task automatic t_narrow();
    load(8'h01);
    chk(mem_size_kb, 16);
    acc(0, 20'h03a5c, 2'h1);
    chk(lat, 12);
    chk(m_addr[15:0], 16'h3a5c);
    chk(rsp_rdata[15:8], 8'h5c ^ 8'hc3);
    acc(0, 20'h04000, 2'h0);
    chk(err, 1);
    chk(m_addr[15:0], 16'h3a5c);
  endtask
  task automatic t_wide();
    rom_base_enable = 1;
    load(8'h0c);
    chk(mem_size_kb, 1024);
    req_wdata = 32'h44332211;
    byte_order_select = 1;
    acc(1, 20'hb5a96, 2'h2);
    chk(lat, 18);
    chk(m_addr, 20'hb5a96);
    chk(m_wdata, 8'h22);
    byte_order_select = 0;
    acc(1, 20'h00001, 2'h2);
    chk(m_wdata, 8'h33);
    chk(m_addr, 20'h00001);
    rom_base_enable = 0;
    acc(0, 20'h00777, 2'h0);
    chk(lat, 14);
    chk(m_addr[15:0], 16'h0777);
  endtask
  task automatic t_pins();
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk);
      irq_pending = k[0];
      dma_control_reg = {4'h0, k[1], 3'h0};
      test_input_n = k[2];
      and_tree_result = k[1];
      local_access = !k[1];
      byte_order_select = k[2];
      stream_index = k[1:0];
      #1;
      chk(irq_n_oe, k[0] | k[1]);
      chk(irq_n_out | !irq_n_oe, !k[0] | !(k[0] | k[1]));
      chk(mem_access_test_out, k[2] ? !k[1] : k[1]);
      chk(stream_lane, k[2] ? 3 - k[1:0] : k[1:0]);
    end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    t_none();
    t_narrow();
    t_wide();
    t_pins();
    finish_test();
  end
endmodule // tb_emp_port
